// ### rtl/static_link_regs.svh
// Register offsets, field positions and reset values of the static link forwarding block
`ifndef STATIC_LINK_REGS_SVH
`define STATIC_LINK_REGS_SVH

// Register indices; byte address is four times the index
`define STATIC_REG_FIRST    10'h0a0
`define STATIC_REG_LAST     10'h0a7
`define STATIC_IDX_W        10

// Field positions inside each static configuration register
`define STATIC_ENABLE_BIT   31
`define STATIC_PROC_BIT     8
`define STATIC_CHAN_MSB     4
`define STATIC_CHAN_LSB     0
`define STATIC_CHAN_W       5

`define STATIC_REG_RESET    32'h0000_0000
`define NUM_LINKS           8

// Register order C,D,A,B,G,H,E,F against links A..H numbered 0..7
`define LINK_REG_SWAP       3'h2

`define AXI_RESP_OKAY       2'h0
`define AXI_RESP_SLVERR     2'h2

`endif

// ### rtl/static_link_pkg.sv
// Types shared by the static link forwarding block
package static_link_pkg;

   typedef struct packed {
      logic [31:0] data;
      logic        last;
   } link_flit_t;

   typedef struct packed {
      logic       static_en;
      logic       dest_proc;
      logic [4:0] dest_chan;
   } static_cfg_t;

   typedef struct packed {
      logic       dest_proc;
      logic [4:0] dest_chan;
   } local_dest_t;

endpackage

// ### rtl/static_link_forwarding.sv
// Static forwarding configuration and per-link steering for the external links of a switch
//
// Contract
// R1: Static-enabled link sends every packet to its configured local endpoint, no route lookup.
// R2: Eight registers in address order govern links C, D, A, B, G, H, E, F.
// R3: One-bit field, reset zero, picks the local processor receiving static traffic.
// R4: Five-bit field, reset zero, picks the local channel endpoint receiving static traffic.
// R5: Each link's enable, processor and endpoint settings are independent of other links.
// R6: Disabled links use normal routing; reserved bits read zero and ignore writes.
`include "static_link_regs.svh"

module static_link_forwarding #(
   parameter int ADDR_W = 12
) (
   input  wire logic                                         sys_clk,
   input  wire logic                                         resetn,
   input  wire logic                                         ce,
   // AXI4-Lite register slave
   input  wire logic [ADDR_W-1:0]                            s_axi_awaddr,
   input  wire logic                                         s_axi_awvalid,
   output logic                                              s_axi_awready,
   input  wire logic [31:0]                                  s_axi_wdata,
   input  wire logic [3:0]                                   s_axi_wstrb,
   input  wire logic                                         s_axi_wvalid,
   output logic                                              s_axi_wready,
   output logic [1:0]                                        s_axi_bresp,
   output logic                                              s_axi_bvalid,
   input  wire logic                                         s_axi_bready,
   input  wire logic [ADDR_W-1:0]                            s_axi_araddr,
   input  wire logic                                         s_axi_arvalid,
   output logic                                              s_axi_arready,
   output logic [31:0]                                       s_axi_rdata,
   output logic [1:0]                                        s_axi_rresp,
   output logic                                              s_axi_rvalid,
   input  wire logic                                         s_axi_rready,
   // Arriving traffic, one stream per link A..H as index 0..7
   input  wire logic [`NUM_LINKS-1:0]                        link_in_valid,
   input  wire static_link_pkg::link_flit_t [`NUM_LINKS-1:0] link_in_flit,
   output logic [`NUM_LINKS-1:0]                             link_in_ready,
   // Static delivery towards local channel endpoints
   output logic [`NUM_LINKS-1:0]                             local_valid,
   output static_link_pkg::link_flit_t [`NUM_LINKS-1:0]      local_flit,
   output static_link_pkg::local_dest_t [`NUM_LINKS-1:0]     local_dest,
   input  wire logic [`NUM_LINKS-1:0]                        local_ready,
   // Routed traffic towards the normal switch routing logic
   output logic [`NUM_LINKS-1:0]                             route_valid,
   output static_link_pkg::link_flit_t [`NUM_LINKS-1:0]      route_flit,
   input  wire logic [`NUM_LINKS-1:0]                        route_ready
);

   // Configuration indexed by register, not by link
   static_link_pkg::static_cfg_t [`NUM_LINKS-1:0] cfg;

   logic [ADDR_W-1:0] aw_addr;
   logic              aw_held;
   logic [31:0]       w_data;
   logic [3:0]        w_strb;
   logic              w_held;

   logic [`STATIC_IDX_W-1:0] wr_idx;
   logic [`STATIC_IDX_W-1:0] rd_idx;
   logic                     wr_hit;
   logic                     rd_hit;
   logic                     do_write;
   logic [2:0]               wr_sel;
   logic [2:0]               rd_sel;
   logic                     wr_en_static;
   logic                     wr_en_proc;
   logic                     wr_en_chan;
   logic [31:0]              rd_word;

   // Index decode; address bits above the index width are cut off by the cast and not checked
   always_comb begin
      wr_idx = `STATIC_IDX_W'(aw_addr[ADDR_W-1:2]);
      rd_idx = `STATIC_IDX_W'(s_axi_araddr[ADDR_W-1:2]);
      wr_hit = (wr_idx >= `STATIC_REG_FIRST) && (wr_idx <= `STATIC_REG_LAST);
      rd_hit = (rd_idx >= `STATIC_REG_FIRST) && (rd_idx <= `STATIC_REG_LAST);
      wr_sel = 3'(wr_idx - `STATIC_REG_FIRST);
      rd_sel = 3'(rd_idx - `STATIC_REG_FIRST);
      do_write = aw_held && w_held && !s_axi_bvalid;
   end

   // Each live field sits in one byte lane; other lanes have nothing to write
   always_comb begin
      wr_en_static = do_write && wr_hit && w_strb[`STATIC_ENABLE_BIT / 8];
      wr_en_proc   = do_write && wr_hit && w_strb[`STATIC_PROC_BIT / 8];
      wr_en_chan   = do_write && wr_hit && w_strb[`STATIC_CHAN_LSB / 8];
   end

   // Read word; reserved bits are never loaded, so they read as zero
   always_comb begin
      rd_word = `STATIC_REG_RESET;                                             // [R6]
      if (rd_hit) begin
         rd_word[`STATIC_ENABLE_BIT]                = cfg[rd_sel].static_en;
         rd_word[`STATIC_PROC_BIT]                  = cfg[rd_sel].dest_proc;
         rd_word[`STATIC_CHAN_MSB:`STATIC_CHAN_LSB] = cfg[rd_sel].dest_chan;
      end
   end

   // Write address, captured once and held until the write is done
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         aw_addr <= '0;
      end else if (ce && s_axi_awvalid && s_axi_awready) begin
         aw_addr <= s_axi_awaddr;
      end
   end

   // Write address channel
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         aw_held       <= 1'b0;
         s_axi_awready <= 1'b1;
      end else if (ce) begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held       <= 1'b1;
            s_axi_awready <= 1'b0;
         end else if (do_write) begin
            aw_held       <= 1'b0;
            s_axi_awready <= 1'b1;
         end
      end
   end

   // Write data and strobes, captured once
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         w_data <= '0;
         w_strb <= '0;
      end else if (ce && s_axi_wvalid && s_axi_wready) begin
         w_data <= s_axi_wdata;
         w_strb <= s_axi_wstrb;
      end
   end

   // Write data channel, taken independently of the address
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         w_held       <= 1'b0;
         s_axi_wready <= 1'b1;
      end else if (ce) begin
         if (s_axi_wvalid && s_axi_wready) begin
            w_held       <= 1'b1;
            s_axi_wready <= 1'b0;
         end else if (do_write) begin
            w_held       <= 1'b0;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // Write response valid; set and clear never meet, do_write needs bvalid low
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         s_axi_bvalid <= 1'b0;
      end else if (ce) begin
         if (do_write) begin
            s_axi_bvalid <= 1'b1;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Write response code; unmapped writes have no effect
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         s_axi_bresp <= `AXI_RESP_OKAY;
      end else if (ce && do_write) begin
         s_axi_bresp <= wr_hit ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
      end
   end

   // Configuration store; only the three fields exist, so reserved bits drop writes
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         cfg <= '0;                                                            // [R3] [R4]
      end else if (ce) begin
         if (wr_en_static) begin
            cfg[wr_sel].static_en <= w_data[`STATIC_ENABLE_BIT];               // [R5]
         end
         if (wr_en_proc) begin
            cfg[wr_sel].dest_proc <= w_data[`STATIC_PROC_BIT];                 // [R3]
         end
         if (wr_en_chan) begin
            cfg[wr_sel].dest_chan <= w_data[`STATIC_CHAN_MSB:`STATIC_CHAN_LSB]; // [R4]
         end
      end
   end

   // Read address channel; one read outstanding
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         s_axi_arready <= 1'b1;
      end else if (ce) begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_arready <= 1'b1;
         end
      end
   end

   // Read valid rises one cycle after the address is taken
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         s_axi_rvalid <= 1'b0;
      end else if (ce) begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // Read word and code are loaded once and stand until the master takes them
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         s_axi_rdata <= `STATIC_REG_RESET;
         s_axi_rresp <= `AXI_RESP_OKAY;
      end else if (ce && s_axi_arvalid && s_axi_arready) begin
         s_axi_rdata <= rd_word;                                               // [R6]
         s_axi_rresp <= rd_hit ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
      end
   end

   // Per-link steering stage
   for (genvar g = 0; g < `NUM_LINKS; g++) begin : g_link
      // Register slot governing this link
      localparam logic [2:0] REG_SEL = 3'(g) ^ `LINK_REG_SWAP;                // [R2]

      static_link_pkg::static_cfg_t pkt_mode;
      static_link_pkg::static_cfg_t next_mode;
      logic                         mid_pkt;
      logic                         taken;
      logic                         drained;

      // Mode is frozen at a packet's first word so a packet is never split
      always_comb begin
         next_mode = mid_pkt ? pkt_mode : cfg[REG_SEL];                        // [R5]
         taken     = link_in_valid[g] && link_in_ready[g];
         drained   = (local_valid[g] && local_ready[g]) ||
                     (route_valid[g] && route_ready[g]);
      end

      always_ff @(posedge sys_clk or negedge resetn) begin
         if (!resetn) begin
            mid_pkt  <= 1'b0;
            pkt_mode <= '0;
         end else if (ce && taken) begin
            mid_pkt  <= !link_in_flit[g].last;
            pkt_mode <= next_mode;
         end
      end

      // One-word slot; ready is registered, costing a bubble per word
      always_ff @(posedge sys_clk or negedge resetn) begin
         if (!resetn) begin
            link_in_ready[g] <= 1'b1;
         end else if (ce) begin
            if (taken) begin
               link_in_ready[g] <= 1'b0;
            end else if (drained) begin
               link_in_ready[g] <= 1'b1;
            end
         end
      end

      // Static delivery; word and destination stand until the endpoint takes them
      always_ff @(posedge sys_clk or negedge resetn) begin
         if (!resetn) begin
            local_valid[g] <= 1'b0;
            local_flit[g]  <= '0;
            local_dest[g]  <= '0;
         end else if (ce) begin
            if (taken) begin
               local_valid[g] <= next_mode.static_en;                          // [R1]
               local_flit[g]  <= link_in_flit[g];
               local_dest[g]  <= '{dest_proc: next_mode.dest_proc,
                                   dest_chan: next_mode.dest_chan};            // [R3] [R4]
            end else if (local_valid[g] && local_ready[g]) begin
               local_valid[g] <= 1'b0;
            end
         end
      end

      // Routed path for words of a packet whose link is not static
      always_ff @(posedge sys_clk or negedge resetn) begin
         if (!resetn) begin
            route_valid[g] <= 1'b0;
            route_flit[g]  <= '0;
         end else if (ce) begin
            if (taken) begin
               route_valid[g] <= !next_mode.static_en;                         // [R6]
               route_flit[g]  <= link_in_flit[g];
            end else if (route_valid[g] && route_ready[g]) begin
               route_valid[g] <= 1'b0;
            end
         end
      end
   end

endmodule

// ### dv/static_link_forwarding_sva.sv
// Port timing checker for the static link forwarding block
module static_link_forwarding_sva (
   input wire logic        sys_clk,
   input wire logic        resetn,
   input wire logic        ce,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [7:0]  link_in_valid,
   input wire logic [7:0]  link_in_ready,
   input wire logic [7:0]  local_valid,
   input wire logic [7:0]  local_ready,
   input wire logic [7:0]  route_valid,
   input wire logic [7:0]  route_ready
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready && ce |=> s_axi_rvalid)
      else $error("read request not answered");
   a_read_hold: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped before taken");
   a_reserved_zero: assert property (s_axi_rvalid
      |-> s_axi_rdata[30:9] == 22'h0 && s_axi_rdata[7:5] == 3'h0)
      else $error("reserved bits not zero");
   a_ce_freeze: assert property (!ce |=> $stable(s_axi_rvalid) && $stable(s_axi_bvalid)
      && $stable(local_valid) && $stable(route_valid) && $stable(link_in_ready))
      else $error("state moved while clock enable low");
   a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped");
   for (genvar i = 0; i < 8; i++) begin : g_link
      // Exactly one path per word: static delivery never also routed
      a_one_path: assert property (link_in_valid[i] && link_in_ready[i] && ce
         |=> local_valid[i] != route_valid[i])
         else $error("word not sent on exactly one path");
      a_slot_busy: assert property (local_valid[i] || route_valid[i] |-> !link_in_ready[i])
         else $error("link accepts while slot full");
      a_local_hold: assert property (local_valid[i] && !local_ready[i] |=> local_valid[i])
         else $error("local word dropped");
      a_route_hold: assert property (route_valid[i] && !route_ready[i] |=> route_valid[i])
         else $error("routed word dropped");
   end
endmodule

bind static_link_forwarding static_link_forwarding_sva u_sva (.*);

// ### dv/link_sink.sv
// Far-side model: local channel endpoints and routing logic taking words
module link_sink (
   input  wire logic       sys_clk,
   input  wire logic       resetn,
   input  wire logic       slow,
   output logic [7:0]      local_ready,
   output logic [7:0]      route_ready
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] s;
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn)
         s <= 16'hace1;
      else
         s <= {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   end
   // Slow mode stalls most cycles so slots stay full
   assign local_ready = slow ? (s[7:0] & s[15:8]) : 8'hff;
   assign route_ready = slow ? (s[8:1] & s[12:5]) : 8'hff;
endmodule

// ### dv/static_link_forwarding_test.sv
// Self-checking bench for the static link forwarding block
module static_link_forwarding_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic        sys_clk = 1'b0, resetn = 1'b0, ce = 1'b1, slow = 1'b0, go = 1'b0, v, l;
   logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic        s_axi_arvalid = 0, s_axi_rready = 0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, seed = 32'h0000_2e04;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [7:0]  link_in_valid = 8'h0, link_in_ready, local_valid, local_ready;
   logic [7:0]  route_valid, route_ready, open = 8'h0;
   static_link_pkg::link_flit_t [7:0]  link_in_flit = '0, local_flit, route_flit;
   static_link_pkg::local_dest_t [7:0] local_dest;
   logic [31:0] cfg [8] = '{default: 32'h0};
   logic [33:0] rq [$];
   logic [39:0] lq [8][$];
   int          fails = 0, tests_run = 0, pending = 0;
   always #4 sys_clk = ~sys_clk;
   static_link_forwarding u_dut (.*);
   link_sink u_sink (.sys_clk, .resetn, .slow, .local_ready, .route_ready);
   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction
   task automatic chk(input string what, input logic [39:0] exp, input logic [39:0] seen);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] st);
      // Model keeps only the three live fields, lane by lane
      if (a[11:5] == 7'h14) begin
         if (st[3]) cfg[a[4:2]][31] = d[31];
         if (st[1]) cfg[a[4:2]][8] = d[8];
         if (st[0]) cfg[a[4:2]][4:0] = d[4:0];
      end
      rq.push_back({a[11:5] == 7'h14 ? 2'h0 : 2'h2, 32'h0});
      @(posedge sys_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= st;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      forever begin
         @(posedge sys_clk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a);
      rq.push_back(a[11:5] == 7'h14 ? {2'h0, cfg[a[4:2]]} : {2'h2, 32'h0});
      @(posedge sys_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      forever begin
         @(posedge sys_clk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      s_axi_rready <= 1'b0;
   endtask
   // Link driver: an open packet is closed with a last word before traffic stops
   always @(posedge sys_clk) begin
      for (int i = 0; i < 8; i++) begin
         if ((go || open[i]) && (!link_in_valid[i] || (link_in_ready[i] && ce))) begin
            seed = xs(seed);
            v = seed[9] || !go;
            l = seed[3] || !go;
            link_in_valid[i] <= v;
            link_in_flit[i] <= {seed, l};
            if (v) begin
               open[i] = !l;
               pending++;
               lq[i].push_back(cfg[i ^ 2][31] ? {1'b1, cfg[i ^ 2][8], cfg[i ^ 2][4:0], seed, l}
                                              : {1'b0, 6'h0, seed, l});
            end
         end else if (link_in_ready[i] && ce)
            link_in_valid[i] <= 1'b0;
      end
   end
   always @(posedge sys_clk) begin
      if (ce && s_axi_rvalid && s_axi_rready)
         chk("read", {6'h0, rq.pop_front()}, {6'h0, s_axi_rresp, s_axi_rdata});
      if (ce && s_axi_bvalid && s_axi_bready)
         chk("write", {6'h0, rq.pop_front()}, {6'h0, s_axi_bresp, 32'h0});
      for (int i = 0; i < 8; i++) begin
         if (ce && local_valid[i] && local_ready[i]) begin
            pending--;
            chk("local", lq[i].pop_front(), {1'b1, local_dest[i], local_flit[i]});
         end
         if (ce && route_valid[i] && route_ready[i]) begin
            pending--;
            chk("routed", lq[i].pop_front(), {7'h0, route_flit[i]});
         end
      end
   end
   initial begin
      repeat (2) @(posedge sys_clk);
      resetn <= 1'b1;
      for (int k = 0; k < 8; k++) rd(12'h280 + 12'(k * 4));
      rd(12'h2a0);
      wr(12'h27c, 32'hffff_ffff, 4'hf);
      for (int p = 0; p < 2; p++) begin
         for (int k = 0; k < 8; k++) begin
            seed = xs(seed);
            wr(12'h280 + 12'(k * 4), seed, p ? 4'hf : seed[7:4]);
            rd(12'h280 + 12'(k * 4));
         end
         slow <= p[0];
         go <= 1'b1;
         repeat (150) @(posedge sys_clk);
         // Frozen stretch mid-traffic: no word may move while enable is low
         ce <= 1'b0;
         repeat (6) @(posedge sys_clk);
         ce <= 1'b1;
         repeat (150) @(posedge sys_clk);
         go <= 1'b0;
         repeat (400) if (pending != 0 || open != 8'h0) @(posedge sys_clk);
         // A drain that runs out of time counts as a mismatch
         chk("drain", 40'h0, {31'h0, pending != 0, open});
      end
      give_verdict;
   end
   initial begin
      repeat (20000) @(posedge sys_clk);
      fails++;
      give_verdict;
   end
endmodule
